// file: sdo_pkg.sv
// sdo_pkg: constants, types and the word builder for the serial result port
// assumes one clock (master clock) and a synchronous active-low reset

`default_nettype none

package sdo_pkg;

  // ***************************************************************
  // frame layout
  // ***************************************************************
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 8;
  localparam int RES_BITS = 24;
  localparam logic [4:0] BIT_LAST = 5'h1F;   // last bit of a frame
  localparam logic [4:0] BIT_PRELAST = 5'h1E; // bit before the last one
  localparam int HDR_ERR_BIT = 7;
  localparam int HDR_UNSETTLED_BIT = 6;
  localparam int HDR_REPEAT_BIT = 5;
  localparam int HDR_FILTER_BIT = 4;
  localparam int HDR_SAT_BIT = 3;
  localparam int HDR_CHAN_LSB = 0;
  localparam int CHAN_ID_BITS = 3;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [6:0] REG_DATA_CONTROL = 7'h06;
  localparam logic [7:0] DATA_CONTROL_RESET = 8'h00;
  localparam int DC_ONESHOT_BIT = 4;

  // ***************************************************************
  // pin-control modes and startup timing
  // ***************************************************************
  localparam logic [3:0] MODE_MED_DIV1 = 4'h4;
  localparam logic [3:0] MODE_FAST_DIV1 = 4'h8;
  localparam logic [3:0] MODE_FAST_DIV4 = 4'hA;
  localparam logic [3:0] MODE_ONESHOT_MIN = 4'hC;
  localparam logic [1:0] DIV4_LAST_PHASE = 2'h3;
  localparam logic [1:0] FMT_WAIT_CYC = 2'h3; // pins pass the synchroniser first
  localparam logic [3:0] SPL_ONE = 4'h1;
  localparam logic [3:0] SPL_FOUR = 4'h4;
  localparam logic [3:0] SPL_EIGHT = 4'h8;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b11,
    ST_SETTLE = 2'b10
  } sdo_state_e;

  typedef enum logic [1:0] {
    PWR_LOW = 2'b00,
    PWR_MEDIAN = 2'b01,
    PWR_FAST = 2'b11
  } sdo_power_e;

  // one converter channel as the filters present it
  typedef struct packed {
    logic err;
    logic settled;
    logic repeated;
    logic filter_sinc;
    logic saturated;
    logic [RES_BITS-1:0] result;
  } sdo_chan_s;

  // raw pin bundle, moved through the synchroniser as one word
  typedef struct packed {
    logic serial_ctl;
    logic [3:0] mode;
    logic [1:0] fmt;
    logic sync_n;
  } sdo_pins_s;

  localparam logic [7:0] PINS_RESET = 8'h01; // sync input idles high

  // header then twos-complement result, msb first on the wire
  function automatic logic [FRAME_BITS-1:0] sdo_build_word(sdo_chan_s c, logic [2:0] ch);
    logic [HDR_BITS-1:0] h;
    h = '0;
    h[HDR_ERR_BIT] = c.err;
    h[HDR_UNSETTLED_BIT] = ~c.settled;
    h[HDR_REPEAT_BIT] = c.repeated;
    h[HDR_FILTER_BIT] = c.filter_sinc;
    h[HDR_SAT_BIT] = c.saturated;
    h[HDR_CHAN_LSB +: CHAN_ID_BITS] = ch;
    return {h, c.result};
  endfunction

endpackage

`default_nettype wire

// file: sdo_lane_shift.sv
// sdo_lane_shift: one serial output lane, a loadable shift register
// assumes load, shift and clear come from the frame sequencer on core_clk

`timescale 1ns/1ps
`default_nettype none

module sdo_lane_shift #(
  parameter int W = 32
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic shift,
  input wire logic clear,
  input wire logic [W-1:0] word,
  output logic bit_out
);

  logic [W-1:0] sreg_q;

  if (W < 2) begin : g_chk
    $error("sdo_lane_shift: W must be at least 2");
  end

  // clear wins so an idle lane is always low
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sreg_q <= '0;
    end else if (clear) begin
      sreg_q <= '0;
    end else if (load) begin
      sreg_q <= word;
    end else if (shift) begin
      sreg_q <= {sreg_q[W-2:0], 1'b0}; // zero fill keeps the tail low
    end
  end

  assign bit_out = sreg_q[W-1];

endmodule

`default_nettype wire

// file: sdo_port.sv
// sdo_port: serial result output of a multichannel converter, master side
// assumes core_clk is the master clock; filters and control core share it

`timescale 1ns/1ps
`default_nettype none

module sdo_port
  import sdo_pkg::*;
#(
  parameter int NUM_CH = 8,
  parameter int SETTLE_CYC = 100
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [1:0] lane_format_pins,
  input wire logic [3:0] pin_mode_pins,
  input wire logic serial_ctl_pin,
  input wire logic sync_req_n,
  input wire logic sample_valid,
  input wire sdo_chan_s [NUM_CH-1:0] chan_in,
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic serial_bit_clock,
  output logic frame_strobe_n,
  output logic [NUM_CH-1:0] serial_out_lanes,
  output logic filter_reset,
  output sdo_power_e power_mode
);

  localparam int IW = $clog2(NUM_CH);

  if (!(NUM_CH == 8 || NUM_CH == 4)) begin : g_chk_ch
    $error("sdo_port: NUM_CH must be 4 or 8");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_chk_settle
    $error("sdo_port: SETTLE_CYC must fit 16 bits and be nonzero");
  end

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  sdo_pins_s pin_meta_q;
  sdo_pins_s pin_q;
  logic sync_prev_q;
  logic sync_rise;

  // meta stage is read by the second stage only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_meta_q <= PINS_RESET;
      pin_q <= PINS_RESET;
      sync_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= {serial_ctl_pin, pin_mode_pins, lane_format_pins, sync_req_n};
      pin_q <= pin_meta_q;
      sync_prev_q <= pin_q.sync_n;
    end
  end

  // rise of the request, seen two clocks late
  assign sync_rise = pin_q.sync_n & ~sync_prev_q;

  // ***************************************************************
  // lane format, caught once
  // ***************************************************************
  logic [1:0] fmt_wait_q;
  logic fmt_taken_q;
  logic [3:0] spl_q;

  // reset stands for power-up; later pin moves are ignored
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fmt_wait_q <= '0;
      fmt_taken_q <= 1'b0;
      spl_q <= SPL_ONE;
    end else if (!fmt_taken_q) begin
      fmt_wait_q <= fmt_wait_q + 2'h1;
      if (fmt_wait_q == FMT_WAIT_CYC) begin
        fmt_taken_q <= 1'b1;
        if (NUM_CH == 8 && pin_q.fmt[1]) begin
          spl_q <= SPL_EIGHT; // all on lane 0
        end else if (pin_q.fmt[0]) begin
          spl_q <= SPL_FOUR;
        end else begin
          spl_q <= SPL_ONE;
        end
      end
    end
  end

  // ***************************************************************
  // data control register
  // ***************************************************************
  logic [7:0] dc_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dc_q <= DATA_CONTROL_RESET;
      reg_rdata <= '0;
    end else begin
      if (reg_wr && reg_addr == REG_DATA_CONTROL) begin
        dc_q <= reg_wdata;
      end
      reg_rdata <= (reg_addr == REG_DATA_CONTROL) ? dc_q : 8'h00;
    end
  end

  // ***************************************************************
  // mode decode
  // ***************************************************************
  logic os_sel;
  logic div4_sel;
  sdo_power_e pwr_sel;

  always_comb begin
    os_sel = 1'b0;
    div4_sel = 1'b1;
    pwr_sel = PWR_FAST;
    if (pin_q.serial_ctl) begin
      os_sel = dc_q[DC_ONESHOT_BIT];
    end else if (pin_q.mode >= MODE_ONESHOT_MIN) begin
      os_sel = 1'b1;
    end else begin
      case (pin_q.mode)
        MODE_FAST_DIV4: begin
          div4_sel = 1'b1;
        end
        MODE_FAST_DIV1: begin
          div4_sel = 1'b0;
        end
        MODE_MED_DIV1: begin
          div4_sel = 1'b0;
          pwr_sel = PWR_MEDIAN;
        end
        default: begin
          pwr_sel = PWR_LOW;
        end
      endcase
    end
  end

  // ***************************************************************
  // bit clock
  // ***************************************************************
  sdo_state_e st_q;
  logic cfg_div4_q;
  logic cfg_os_q;
  logic [1:0] bit_ph_q;
  logic bclk_q;
  logic bit_tick;

  // config only moves between bursts, so a frame never changes speed
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_div4_q <= 1'b1;
      cfg_os_q <= 1'b0;
      power_mode <= PWR_FAST;
    end else if (st_q == ST_IDLE) begin
      cfg_div4_q <= div4_sel;
      cfg_os_q <= os_sel;
      power_mode <= pwr_sel;
    end
  end

  // free-running divider; the bit clock runs even between frames
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bit_ph_q <= '0;
      bclk_q <= 1'b0;
    end else if (cfg_div4_q) begin
      bit_ph_q <= bit_ph_q + 2'h1;
      bclk_q <= bit_ph_q[1] ^ bit_ph_q[0]; // high in phases 2,3: rises mid-bit
    end else begin
      bit_ph_q <= '0;
      bclk_q <= 1'b0;
    end
  end

  assign bit_tick = !cfg_div4_q || bit_ph_q == DIV4_LAST_PHASE;
  // at full rate the clock itself is forwarded; data moves on its rise
  assign serial_bit_clock = cfg_div4_q ? bclk_q : core_clk;

  // ***************************************************************
  // sequencer control terms
  // ***************************************************************
  logic pend_q;
  logic [15:0] settle_q;
  logic [4:0] bit_cnt_q;
  logic [2:0] slot_q;
  logic strobe_n_q;
  logic any_settled;
  logic go_std;
  logic os_ready;
  logic last_bit;
  logic last_slot;
  logic lane_ld;
  logic lane_sh;
  logic lane_clr;
  logic cap;
  logic [2:0] load_slot;

  always_comb begin
    any_settled = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      any_settled = any_settled | chan_in[i].settled;
    end
  end

  assign go_std = st_q == ST_IDLE && !cfg_os_q && bit_tick && (pend_q || sample_valid);
  assign os_ready = st_q == ST_SETTLE && settle_q == 16'h0000 && bit_tick
                    && any_settled && !sync_rise;
  assign last_bit = st_q == ST_SHIFT && bit_tick && bit_cnt_q == BIT_LAST;
  assign last_slot = {1'b0, slot_q} == spl_q - 4'h1;
  assign lane_ld = (st_q == ST_LEAD && bit_tick) || os_ready || (last_bit && !last_slot);
  assign lane_sh = st_q == ST_SHIFT && bit_tick && bit_cnt_q != BIT_LAST;
  assign lane_clr = last_bit && last_slot;
  assign cap = go_std || os_ready;
  assign load_slot = last_bit ? slot_q + 3'h1 : 3'h0;

  // a result strobe during a busy frame is held; a burst start clears it, even with a new strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
    end else if (sample_valid && !cfg_os_q && !go_std) begin
      pend_q <= 1'b1; // a strobe taken at once must not start a second burst
    end else if (go_std || cfg_os_q) begin
      pend_q <= 1'b0;
    end
  end

  // filters restart on every request rise
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      filter_reset <= 1'b0;
    end else begin
      filter_reset <= sync_rise;
    end
  end

  // ***************************************************************
  // frame sequencer
  // ***************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      settle_q <= '0;
      bit_cnt_q <= '0;
      slot_q <= '0;
      strobe_n_q <= 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          strobe_n_q <= !cfg_os_q; // one-shot idles low
          bit_cnt_q <= '0;
          slot_q <= '0;
          if (cfg_os_q && sync_rise) begin
            st_q <= ST_SETTLE;
            settle_q <= 16'(SETTLE_CYC);
            strobe_n_q <= 1'b0;
          end else if (go_std) begin
            st_q <= ST_LEAD;
            strobe_n_q <= 1'b0;
          end
        end
        ST_LEAD: begin
          if (bit_tick) begin
            st_q <= ST_SHIFT;
            strobe_n_q <= 1'b1;
          end
        end
        ST_SETTLE: begin
          if (sync_rise) begin
            settle_q <= 16'(SETTLE_CYC); // a new request restarts settling
          end else if (settle_q != 16'h0000) begin
            settle_q <= settle_q - 16'h0001;
          end else if (os_ready) begin
            st_q <= ST_SHIFT;
            strobe_n_q <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (bit_tick) begin
            if (last_bit) begin
              bit_cnt_q <= '0;
              if (last_slot) begin
                st_q <= ST_IDLE;
                strobe_n_q <= !cfg_os_q;
              end else begin
                slot_q <= slot_q + 3'h1;
                strobe_n_q <= 1'b1;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + 5'h01;
              // standard mode: next frame announced one bit early
              if (!cfg_os_q && bit_cnt_q == BIT_PRELAST && !last_slot) begin
                strobe_n_q <= 1'b0;
              end
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign frame_strobe_n = strobe_n_q;

  // ***************************************************************
  // result snapshot and lanes
  // ***************************************************************
  logic [FRAME_BITS-1:0] mem_q [NUM_CH];
  logic [FRAME_BITS-1:0] src_word [NUM_CH];

  // all channels are frozen together so one burst is coherent
  always_ff @(posedge core_clk) begin
    if (cap) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_q[i] <= sdo_build_word(chan_in[i], 3'(i));
      end
    end
  end

  // the one-shot path loads the lane in the capture cycle itself
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      src_word[i] = os_ready ? sdo_build_word(chan_in[i], 3'(i)) : mem_q[i];
    end
  end

  for (genvar l = 0; l < NUM_CH; l++) begin : g_lane
    logic [6:0] idx;
    logic [FRAME_BITS-1:0] word;

    // lane l carries channel l*spl+slot; lanes past the last are unused
    always_comb begin
      idx = 7'(l) * {3'b000, spl_q} + {4'h0, load_slot};
      word = (idx < 7'(NUM_CH)) ? src_word[idx[IW-1:0]] : '0;
    end

    sdo_lane_shift #(
      .W(FRAME_BITS)
    ) u_shift (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(lane_ld),
      .shift(lane_sh),
      .clear(lane_clr),
      .word(word),
      .bit_out(serial_out_lanes[l])
    );
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_lead_one_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_q == ST_LEAD && bit_tick) |=> (st_q == ST_SHIFT && frame_strobe_n))
    else $error("strobe did not lead the msb by one bit");

  a_idle_lanes_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> serial_out_lanes == '0)
    else $error("lanes not low while idle");

  a_fmt_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
    (fmt_taken_q && $past(fmt_taken_q)) |-> $stable(spl_q))
    else $error("lane format changed after capture");

  a_sync_resets: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sync_rise && cfg_os_q && st_q == ST_IDLE) |=> (filter_reset && !frame_strobe_n
    && st_q == ST_SETTLE))
    else $error("sync rise did not reset filters and drop strobe");

  a_settle_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_q == ST_SETTLE && settle_q != 16'h0000) |=> (!frame_strobe_n
    && st_q == ST_SETTLE))
    else $error("data left before settling elapsed");

  a_os_frame_high: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg_os_q && st_q == ST_SHIFT) |-> frame_strobe_n)
    else $error("one-shot strobe low during data");

  a_os_stays_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cfg_os_q && st_q == ST_IDLE && !sync_rise) |=> st_q == ST_IDLE)
    else $error("one-shot output without a new request");

  a_frame_next: assert property (@(posedge core_clk) disable iff (!reset_n)
    (last_bit && !last_slot) |=> (bit_cnt_q == 5'h00 && slot_q == $past(slot_q) + 3'h1))
    else $error("frame did not advance after 32 bits");

  a_mode_speed: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!pin_q.serial_ctl && pin_q.mode == MODE_FAST_DIV1) |-> (!div4_sel && !os_sel
    && pwr_sel == PWR_FAST))
    else $error("mode 8 decoded wrongly");

endmodule

`default_nettype wire

// file: sdo_rx_model.sv
// sdo_rx_model: behavioural receiver standing at the far side of the result port
// assumes sdo_port outputs on core_clk; samples at core_clk falls, where lanes are settled

`timescale 1ns/1ps
`default_nettype none

module sdo_rx_model
  import sdo_pkg::*;
(
  input wire logic core_clk,
  input wire logic div1,
  input wire logic [1:0] rx_mode,
  input wire logic serial_bit_clock,
  input wire logic frame_strobe_n,
  input wire logic [7:0] serial_out_lanes,
  output logic [15:0] got_cnt,
  output logic [7:0][31:0] got_word
);
  // ***************************************************************
  // bit capture
  // ***************************************************************
  logic bclk_prev;
  logic [5:0] cnt;
  logic [7:0][31:0] sh;

  initial begin
    got_cnt = '0;
    got_word = '0;
    sh = '0;
    cnt = '0;
    bclk_prev = 1'b0;
  end

  task automatic take;
    for (int l = 0; l < 8; l++) sh[l] = {sh[l][30:0], serial_out_lanes[l]};
  endtask

  // one bit per bit-clock rise; div1 forwards core_clk, so every fall is a bit
  // rx_mode 0 mutes the receiver while the bench switches modes
  always @(negedge core_clk) begin
    if (div1 || (serial_bit_clock && !bclk_prev)) begin
      if (rx_mode == 2'd0) begin
        cnt = '0;
      end else if (rx_mode == 2'd2) begin
        if (!frame_strobe_n) begin
          cnt = '0; // active-high frame
        end else begin
          take();
          cnt = cnt + 6'd1;
          if (cnt == 6'd32) begin
            got_word = sh; // 32 bits per slot
            got_cnt = got_cnt + 16'd1;
            cnt = '0;
          end
        end
      end else begin
        if (cnt != 6'd0) begin
          take();
          cnt = cnt - 6'd1;
          if (cnt == 6'd0) begin
            got_word = sh;
            got_cnt = got_cnt + 16'd1;
          end
        end
        if (!frame_strobe_n) cnt = 6'd32; // msb follows the low strobe bit
      end
    end
    bclk_prev = serial_bit_clock;
  end
endmodule

`default_nettype wire

// file: sdo_port_tb.sv
// sdo_port_tb: self-checking bench for the serial result port
// assumes sdo_port and sdo_rx_model; settle count shortened to 4 clocks

`timescale 1ns/1ps
`default_nettype none

module sdo_port_tb
  import sdo_pkg::*;
;
  logic core_clk, reset_n, sctl, sync_n, sv, reg_wr, div1, bclk, strobe_n, frst;
  logic [1:0] fmt, rx_mode;
  logic [3:0] mode;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, lanes;
  sdo_power_e pwr;
  sdo_chan_s [7:0] chan;
  logic [15:0] got_cnt, cnt0;
  logic [7:0][31:0] got_word;
  logic [31:0] exp_q[$];
  int nl = 0;
  int fail_count = 0;
  int cmp_count = 0;
  int dummy;

  sdo_port #(.NUM_CH(8), .SETTLE_CYC(4)) sdo_port_i (.core_clk(core_clk), .reset_n(reset_n),
    .lane_format_pins(fmt), .pin_mode_pins(mode), .serial_ctl_pin(sctl), .sync_req_n(sync_n),
    .sample_valid(sv), .chan_in(chan), .reg_wr(reg_wr), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .serial_bit_clock(bclk), .frame_strobe_n(strobe_n),
    .serial_out_lanes(lanes), .filter_reset(frst), .power_mode(pwr));

  sdo_rx_model sdo_rx_model_i (.core_clk(core_clk), .div1(div1), .rx_mode(rx_mode),
    .serial_bit_clock(bclk), .frame_strobe_n(strobe_n), .serial_out_lanes(lanes),
    .got_cnt(got_cnt), .got_word(got_word));

  // ***************************************************************
  // clock, shared tasks
  // ***************************************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // reset doubles as power-up, so the format pins are caught afresh
  task automatic do_reset(input logic [1:0] f);
    reset_n = 1'b0;
    fmt = f;
    cyc(12);
    reset_n = 1'b1;
    cyc(10);
  endtask

  task automatic reg_op(input logic wr, input logic [6:0] a, input logic [7:0] d);
    reg_wr = wr;
    addr = a;
    wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(2);
  endtask

  function automatic logic [31:0] mk(input sdo_chan_s c, input int ch);
    return {c.err, ~c.settled, c.repeated, c.filter_sinc, c.saturated, 3'(ch), c.result};
  endfunction

  // new random channel set; expectations noted slot by slot, lane by lane
  task automatic load(input int ln, input int spl, input logic all_settled);
    for (int i = 0; i < 8; i++) begin
      chan[i] = sdo_chan_s'(29'($urandom));
      if (all_settled || i == 0) chan[i].settled = 1'b1; // one settled channel is enough
    end
    nl = ln;
    for (int s = 0; s < spl; s++)
      for (int l = 0; l < ln; l++) exp_q.push_back(mk(chan[l * spl + s], l * spl + s));
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 6000) begin
      cyc(1);
      n++;
    end
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, exp_q.size(), 0);
      exp_q.delete();
    end
    cyc(4);
    check({24'h0, lanes}, 32'h0); // idle lanes held low
  endtask

  task automatic std_frame(input int ln, input int spl);
    load(ln, spl, 1'b0);
    sv = 1'b1;
    cyc(1);
    sv = 1'b0;
    drain();
  endtask

  task automatic shot(input int ln, input int spl, input logic alls);
    int n;
    load(ln, spl, alls);
    sync_n = 1'b0; // request pulse launched on the clock
    cyc(2);
    sync_n = 1'b1;
    sv = 1'b1;
    cyc(1);
    sv = 1'b0;
    n = 0;
    while (frst !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    check({31'h0, frst}, 32'h1);
    check({31'h0, strobe_n}, 32'h0);
    drain(); // first frame already settled
    cnt0 = got_cnt;
    cyc(200);
    check({16'h0, got_cnt}, {16'h0, cnt0}); // silent until next request
  endtask

  // ***************************************************************
  // result monitor: oldest note against each lane in use
  // ***************************************************************
  always @(got_cnt) begin
    for (int l = 0; l < nl; l++) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, got_word[l], 0);
      end else begin
        check(got_word[l], exp_q.pop_front());
      end
    end
  end

  // hang guard, about 30000 clocks, well over the planned run
  initial begin
    #3000000;
    fail_count++;
    $display("FAIL t=%0t seen=%h exp=%h", $time, 0, 1);
    close_out();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    reset_n = 1'b0;
    fmt = 2'b00;
    mode = 4'h8;
    sctl = 1'b0;
    sync_n = 1'b1;
    sv = 1'b0;
    reg_wr = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    chan = '0;
    div1 = 1'b1;
    rx_mode = 2'd1;
    cnt0 = '0;
    dummy = $urandom(32'h6627);
    do_reset(2'b00);
    reg_op(1'b0, 7'h06, 8'h00);
    check({24'h0, rdata}, 32'h0);
    check({30'h0, pwr}, {30'h0, PWR_FAST});
    std_frame(8, 1);
    $display("test 1 done");
    mode = 4'hA;
    div1 = 1'b0;
    cyc(4);
    std_frame(8, 1);
    $display("test 2 done");
    mode = 4'h8;
    div1 = 1'b1;
    do_reset(2'b01);
    std_frame(2, 4);
    fmt = 2'b00;
    cyc(4);
    std_frame(2, 4);
    $display("test 3 done");
    mode = 4'h4;
    do_reset(2'b10);
    check({30'h0, pwr}, {30'h0, PWR_MEDIAN});
    std_frame(1, 8);
    $display("test 4 done");
    rx_mode = 2'd0;
    div1 = 1'b0;
    mode = 4'hC;
    cyc(8);
    rx_mode = 2'd2;
    for (int m = 12; m < 16; m++) begin
      mode = 4'(m);
      cyc(4);
      shot(1, 8, 1'b1);
    end
    $display("test 5 done");
    rx_mode = 2'd0;
    mode = 4'h0;
    sctl = 1'b1;
    cyc(8);
    reg_op(1'b1, 7'h07, 8'h55);
    check({24'h0, rdata}, 32'h0);
    reg_op(1'b1, 7'h06, 8'h10);
    check({24'h0, rdata}, 32'h10);
    cyc(8);
    rx_mode = 2'd2;
    shot(1, 8, 1'b0);
    $display("test 6 done");
    close_out();
  end
endmodule

`default_nettype wire
